/* File: trigger_output_pkg.sv */
// Constants, field layouts and carrier types for the trigger output source selector
package trigger_output_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [15:0] TRIG_MASK_ADDR = 16'h8110;
   localparam logic [15:0] FP_CTRL_ADDR = 16'h811C;
   localparam logic [15:0] FP_STATUS_ADDR = 16'h81F0;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int NUM_TRIG_SRC = 8;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Front-panel control field positions
   localparam int FORCE_LEVEL_BIT = 14;
   localparam int TEST_MODE_BIT = 15;
   localparam int MODE_LSB = 16;
   localparam int PROBE_LSB = 18;
   localparam int QUALIFIER_BIT = 20;
   localparam int CFG_W = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Status field positions
   localparam int ST_OUT_BIT = 0;
   localparam int ST_TRIG_BIT = 1;
   localparam int ST_SYNC_BIT = 2;
   localparam int ST_CLK_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and the read value of unmapped addresses
   localparam logic [NUM_TRIG_SRC-1:0] TRIG_MASK_RESET = 8'h00;
   localparam logic [CFG_W-1:0] FP_CTRL_RESET = 7'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // Modes and probes
   typedef enum logic [1:0] {
      OUT_TRIGGER = 2'b00,
      OUT_MB_PROBE = 2'b01,
      OUT_CH_PROBE = 2'b10,
      OUT_SYNC_IN = 2'b11
   } out_mode_t;

   typedef enum logic [1:0] {
      PROBE_RUN = 2'b00,
      PROBE_CLOCK = 2'b01,
      PROBE_PHASE = 2'b10,
      PROBE_STATUS = 2'b11
   } mb_probe_t;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic qualifier;
      mb_probe_t probe;
      out_mode_t mode;
      logic testMode;
      logic forceLevel;
   } out_cfg_t;

   typedef struct packed {
      logic run;
      logic delayedAcquisitionFlag;
      logic busy;
      logic lockLoss;
   } board_flags_t;

endpackage

/* File: trigger_output_source_select.sv */
// Trigger output source selector with APB register access
`timescale 1ns/100ps

module trigger_output_source_select (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Signal sources
   input wire logic [7:0] triggerSources,
   input wire trigger_output_pkg::board_flags_t boardFlags,
   input wire logic channelProbe,
   input wire logic general_purpose_input,
   // Front-panel output
   output logic trigger_output_pin
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and combinational next values
   logic [7:0] trigMask;
   trigger_output_pkg::out_cfg_t cfg;
   logic samplingClockCopy;
   logic [31:0] next_prdata;
   logic next_out;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire logic accessing = psel & penable & ~pready;
   wire logic commit = psel & penable & pready;
   wire logic hitMask = (paddr == trigger_output_pkg::TRIG_MASK_ADDR);
   wire logic hitCtrl = (paddr == trigger_output_pkg::FP_CTRL_ADDR);
   wire logic hitStatus = (paddr == trigger_output_pkg::FP_STATUS_ADDR);
   wire logic mapped = hitMask | hitCtrl | hitStatus;
   // Status is read only, so writing it is an error too
   wire logic badAccess = ~mapped | (pwrite & hitStatus);

   ////////////////////////////////////////////////////////////////////////////
   // Source selection
   wire logic combinedTrigger = |(triggerSources & trigMask);
   wire logic runProbe = cfg.qualifier ? boardFlags.delayedAcquisitionFlag : boardFlags.run;
   wire logic statusProbe = cfg.qualifier ? boardFlags.lockLoss : boardFlags.busy;

   logic mbProbe;
   always_comb begin
      unique case (cfg.probe)
         trigger_output_pkg::PROBE_RUN: mbProbe = runProbe;
         trigger_output_pkg::PROBE_CLOCK: mbProbe = samplingClockCopy;
         // Phase view: the copy half a period late, opposite polarity
         trigger_output_pkg::PROBE_PHASE: mbProbe = ~samplingClockCopy;
         trigger_output_pkg::PROBE_STATUS: mbProbe = statusProbe;
      endcase
   end

   logic modeOut;
   always_comb begin
      unique case (cfg.mode)
         trigger_output_pkg::OUT_TRIGGER: modeOut = combinedTrigger;
         trigger_output_pkg::OUT_MB_PROBE: modeOut = mbProbe;
         trigger_output_pkg::OUT_CH_PROBE: modeOut = channelProbe;
         trigger_output_pkg::OUT_SYNC_IN: modeOut = general_purpose_input;
      endcase
   end

   assign next_out = cfg.testMode ? cfg.forceLevel : modeOut;

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   wire logic [31:0] maskWord = {24'h000000, trigMask};
   wire logic [31:0] ctrlWord = {11'h000, cfg.qualifier, cfg.probe, cfg.mode, cfg.testMode, cfg.forceLevel,
                                 14'h0000};
   wire logic [31:0] statusWord = {28'h0000000, samplingClockCopy, general_purpose_input, combinedTrigger,
                                   trigger_output_pin};
   assign next_prdata = hitMask ? maskWord :
                        hitCtrl ? ctrlWord :
                        hitStatus ? statusWord : trigger_output_pkg::READ_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer, one wait state
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= accessing;
         pslverr <= accessing & badAccess;
         prdata <= (accessing & ~pwrite) ? next_prdata : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration, written at the completing edge only
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         trigMask <= trigger_output_pkg::TRIG_MASK_RESET;
         cfg <= trigger_output_pkg::FP_CTRL_RESET;
      end else if (commit & pwrite) begin
         if (hitMask) begin
            trigMask <= pwdata[7:0];
         end
         if (hitCtrl) begin
            cfg <= pwdata[trigger_output_pkg::QUALIFIER_BIT:trigger_output_pkg::FORCE_LEVEL_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Half-rate clock copy; edges stay locked to the sampling clock
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         samplingClockCopy <= 1'b0;
      end else begin
         samplingClockCopy <= ~samplingClockCopy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output flop hides mux glitches when fields change
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         trigger_output_pin <= 1'b0;
      end else begin
         trigger_output_pin <= next_out;
      end
   end

endmodule // trigger_output_source_select

/* File: sync_neighbour_model.sv */
// Neighbouring board model driving the sync input
`timescale 1ns/100ps
module sync_neighbour_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Sync line, changes every second cycle
   output logic general_purpose_input
);
   logic [1:0] phase;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) phase <= 2'h0;
      else phase <= phase + 2'h1;
   end
   assign general_purpose_input = phase[1];
endmodule // sync_neighbour_model

/* File: trigger_output_source_select_assertions.sv */
// Checker for the trigger output source selector
`timescale 1ns/100ps
module trigger_output_checker (
   // Bus
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Pins
   input wire logic [7:0] triggerSources,
   input wire trigger_output_pkg::board_flags_t boardFlags,
   input wire logic channelProbe,
   input wire logic general_purpose_input,
   input wire logic trigger_output_pin
);
   // Shadow of the fields, snooped off completed writes
   logic [6:0] c;
   logic [7:0] m;
   wire wr = psel && penable && pready && pwrite;
   wire pin = trigger_output_pin;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         c <= 7'h00;
         m <= 8'h00;
      end else begin
         if (wr && paddr == 16'h811C) c <= pwdata[20:14];
         if (wr && paddr == 16'h8110) m <= pwdata[7:0];
      end
   end
   a_force_level: assert property (c[1] |=> pin == $past(c[0])) else $error("forced level");
   a_trigger_mode: assert property (c[3:1] == 3'h0 |=> pin == $past(|(triggerSources & m))) else $error("trig");
   a_channel_probe: assert property (c[3:1] == 3'h4 |=> pin == $past(channelProbe)) else $error("channel");
   a_sync_pass: assert property (c[3:1] == 3'h6 |=> pin == $past(general_purpose_input)) else $error("sync");
   a_run_probe: assert property (c[5:1] == 5'h02 |=> pin == $past(c[6] ? boardFlags[2] : boardFlags[3]))
      else $error("run");
   a_clock_copy: assert property ((c[5:1] == 5'h0A) [*2] |=> pin != $past(pin)) else $error("clock");
   a_status_probe: assert property (c[5:1] == 5'h1A |=> pin == $past(c[6] ? boardFlags[0] : boardFlags[1]))
      else $error("status");
   a_bus_answer: assert property (psel && !penable |-> ##2 pready) else $error("late answer");
endmodule // trigger_output_checker
bind trigger_output_source_select trigger_output_checker trigger_output_checker_i (
   .sys_clk(sys_clk),
   .rst_b(rst_b),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pready(pready),
   .triggerSources(triggerSources),
   .boardFlags(boardFlags),
   .channelProbe(channelProbe),
   .general_purpose_input(general_purpose_input),
   .trigger_output_pin(trigger_output_pin)
);

/* File: trigger_output_source_select_bench.sv */
// Bench for the trigger output source selector
`timescale 1ns/100ps
module trigger_output_source_select_bench;
   logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, channelProbe = 1;
   logic general_purpose_input, trigger_output_pin, pready, pslverr, e, g;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000, prdata, r;
   logic [7:0] triggerSources = 8'h24;
   trigger_output_pkg::board_flags_t boardFlags = 4'h9;
   int fails = 0, totalChecks = 0;
   initial forever #12.5 sys_clk = ~sys_clk;
   sync_neighbour_model sync_neighbour_model_i (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .general_purpose_input(general_purpose_input)
   );
   trigger_output_source_select trigger_output_source_select_i (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .triggerSources(triggerSources),
      .boardFlags(boardFlags),
      .channelProbe(channelProbe),
      .general_purpose_input(general_purpose_input),
      .trigger_output_pin(trigger_output_pin)
   );
   task automatic chk(input logic [31:0] s, x);
      totalChecks++;
      if (s !== x) begin
         fails++;
         $display("ERROR at %0t: %h vs %h", $time, s, x);
      end
   endtask
   task automatic testDone();
      $display("%0d checks, %0d fails", totalChecks, fails);
      if (fails == 0 && totalChecks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Bounded wait: a slave that never answers ends the run
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n = 0;
      psel <= '1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= '1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 9);
      if (pready !== 1'b1) begin
         fails++;
         testDone();
      end
      r = prdata;
      e = pslverr;
      psel <= '0;
      penable <= '0;
      @(posedge sys_clk);
   endtask
   task automatic regScan();
      apb('0, 16'h811C, 32'h00000000);
      chk(r, 32'h00000000);
      apb('1, 16'h8110, 32'h00000004);
      apb('0, 16'h8110, 32'h00000000);
      chk(r, 32'h00000004);
      apb('0, 16'h8120, 32'h00000000);
      chk({r[30:0], e}, 32'h00000001);
      // Only bits 20 to 14 of control may stick
      apb('1, 16'h811C, 32'hFFFFFFFF);
      apb('0, 16'h811C, 32'h00000000);
      chk(r, 32'h001FC000);
      // Status is read only: refused, no effect
      apb('1, 16'h81F0, 32'hFFFFFFFF);
      chk({r[30:0], e}, 32'h00000001);
      apb('0, 16'h81F0, 32'h00000000);
      chk(r & 32'hFFFFFFF3, 32'h00000003);
      $display("register scan done");
   endtask
   // Flags differ per probe so a wrong pick shows
   task automatic modeScan();
      logic [7:0] t [8] = '{8'h01, 8'h09, 8'h88, 8'h68, 8'hE9, 8'h11, 8'h17, 8'h14};
      foreach (t[i]) begin
         apb('1, 16'h811C, {11'h000, t[i][7:1], 14'h0000});
         repeat (2) @(posedge sys_clk);
         chk(trigger_output_pin, t[i][0]);
      end
      // Enabled source (bit 2) and channel probe low, others high, so a stuck-high source path shows
      triggerSources <= 8'hFB;
      apb('1, 16'h811C, 32'h00000000);
      repeat (2) @(posedge sys_clk);
      chk(trigger_output_pin, 1'b0);
      channelProbe <= '0;
      apb('1, 16'h811C, 32'h00020000);
      repeat (2) @(posedge sys_clk);
      chk(trigger_output_pin, 1'b0);
      $display("mode scan done");
   endtask
   task automatic waveScan();
      logic [31:0] w [3] = '{32'h00050000, 32'h00030000, 32'h00090000};
      foreach (w[i]) begin
         apb('1, 16'h811C, w[i]);
         #1;
         repeat (6) begin
            g = (i == 1) ? general_purpose_input : ~trigger_output_pin;
            @(posedge sys_clk);
            #1;
            chk(trigger_output_pin, g);
         end
         @(posedge sys_clk);
      end
      $display("wave scan done");
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_b <= '1;
      regScan();
      modeScan();
      waveScan();
      testDone();
   end
endmodule // trigger_output_source_select_bench
